// ==== frs_defines.svh ====
// Constants for the fault restart sequencer: codes, ranges and timing counts.
// Assumes a 50 MHz control clock; included by the tick divider and sequencer files.
`ifndef FRS_DEFINES_SVH
`define FRS_DEFINES_SVH

`define FRS_CLK_HZ          50000000
`define FRS_TICK_S_DIV      10
`define FRS_TICK_CYCLES     (`FRS_CLK_HZ / `FRS_TICK_S_DIV)
`define FRS_MODE_TRIP       3'h0
`define FRS_MODE_ZERO       3'h1
`define FRS_MODE_MATCH      3'h2
`define FRS_MODE_MATCH_TRIP 3'h3
`define FRS_MODE_ACTIVE     3'h4
`define FRS_STOP_NO_TRIP    2'h0
`define FRS_STOP_TRIP       2'h1
`define FRS_STOP_NO_DECEL   2'h2
`define FRS_WAIT_MIN        10'h003
`define FRS_WAIT_MAX        10'h3e8
`define FRS_DROP_MAX        10'h0fa
`define FRS_RETRY_MIN       2'h1
`define FRS_RETRY_MAX       2'h3

`endif

// ==== frs_pkg.sv ====
// Types shared by the fault restart sequencer files.
// Assumes frs_defines.svh is on the include path.
package frs_pkg;
    typedef enum logic [2:0] {
        FRS_RS_NONE,
        FRS_RS_ZERO,
        FRS_RS_MATCH,
        FRS_RS_ACTIVE
    } frs_restart_t;

    typedef struct packed {
        logic [2:0] power_fail_restart_mode;
        logic [9:0] dropout_allowed_time;
        logic [9:0] power_fail_retry_wait;
        logic [1:0] stop_state_trip_select;
        logic [2:0] ovoc_restart_mode;
        logic [1:0] ovoc_retry_count;
        logic [9:0] ovoc_retry_wait;
    } frs_cfg_t;

    typedef struct packed {
        logic         output_enable;
        logic         restart_req;
        frs_restart_t restart_kind;
        logic         decel_stop_req;
        logic         undervoltage_error;
        logic         alarm_output;
        logic         trip;
    } frs_ctl_t;
endpackage : frs_pkg

// ==== frs_tick.sv ====
// Divider giving a one-cycle enable every 0.1 s of the control clock.
// Assumes the 50 MHz clock and a synchronous active-high reset.
`timescale 1ns/100ps
`include "frs_defines.svh"

// The period is a parameter so that a bench can shorten the waits to fit a run.
module frs_tick #(
    parameter int unsigned TICK_CYCLES = `FRS_TICK_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    output logic      tick
);
    localparam logic [22:0] LAST = 23'(TICK_CYCLES - 1);

    typedef struct packed {
        logic [22:0] cnt;
        logic        tick;
    } frs_tick_st_t;

    frs_tick_st_t st, next_st;

    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (st.cnt == LAST) begin
            next_st.cnt  = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 23'h000001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

    tick_period_a: assert property (@(posedge clk) disable iff (rst)
        tick |=> !tick [*8]) else $error("tick repeated too soon");
endmodule : frs_tick

// ==== frs_sequencer.sv ====
// Fault restart sequencer: reacts to supply dropout and to overvoltage or
// overcurrent faults by tripping or by coasting, waiting and restarting.
// Assumes settings and fault inputs are synchronous to clk; the frequency
// matching and deceleration themselves are done by the drive outside.
`timescale 1ns/100ps
`include "frs_defines.svh"

// Summary of operation
// RL1: Power-fail trip mode: cut output, on timely return raise undervoltage error and alarm.
// RL2: Any dropout immediately disables the output so the motor coasts.
// RL3: Power-fail mode 01: wait after return, restart from zero, no alarm.
// RL4: Power-fail mode 02: wait, frequency-matched restart at held frequency, no alarm.
// RL5: Power-fail mode 03: matched restart after wait, then decelerate and alarm.
// RL6: Power-fail mode 04: wait, active matching restart, alarm stays off.
// RL7: Stop-state setting: 00 no trip, 01 trip, 02 none while stopped or decelerating; the code runs the power-fail sequence for 01 while decelerating.
// RL8: A stop-state dropout trip stays asserted while control power remains.
// RL9: Fault mode: 00 trip, 01 zero, 02 matched, 03 matched then trip, 04 active.
// RL10: Fault restarts repeat up to retry count 1 to 3, then trip.
// RL11: Fault modes 02 and 03 restart by matching at interrupted frequency.
// RL12: Fault restart held off retry wait 0.3 to 100.0 s from detection.
// RL13: Fault still present when wait ends detects trip again.
// RL14: Power-fail retry wait runs from power return, 0.3 to 100.0 s.
// RL15: Restart only if power returns within allowed time 0.3 to 25.0 s.
// RL16: Retry counter cleared on reset; all waits timed in 0.1 s ticks.
// RL17: Reserved setting encodings fall back to the trip response.
module frs_sequencer #(
    parameter int unsigned TICK_CYCLES = `FRS_TICK_CYCLES
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  frs_pkg::frs_cfg_t cfg,
    input  wire logic         dropout,
    input  wire logic         ovoc_fault,
    input  wire logic         running,
    input  wire logic         decel_stopping,
    input  wire logic         decel_done,
    input  wire logic         control_power,
    output frs_pkg::frs_ctl_t ctl
);
    typedef enum logic [2:0] {
        S_RUN,
        S_PF_OUT,
        S_PF_WAIT,
        S_OV_WAIT,
        S_DECEL,
        S_TRIPPED
    } frs_state_t;

    typedef struct packed {
        frs_state_t        state;
        logic [9:0]        timer;
        logic [1:0]        retries;
        logic [2:0]        mode;
        frs_pkg::frs_ctl_t ctl;
    } frs_st_t;

    frs_st_t st, next_st;
    logic    tick;

    frs_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .clk  (clk),
        .rst  (rst),
        .tick (tick)
    );

    // Reserved codes collapse to trip, so an unknown setting never restarts.
    function automatic logic [2:0] legal_mode(input logic [2:0] m);
        legal_mode = (m > `FRS_MODE_ACTIVE) ? `FRS_MODE_TRIP : m; // RL17
    endfunction : legal_mode

    function automatic logic [9:0] clamp_wait(input logic [9:0] w, input logic [9:0] hi);
        clamp_wait = (w < `FRS_WAIT_MIN) ? `FRS_WAIT_MIN : ((w > hi) ? hi : w);
    endfunction : clamp_wait

    function automatic frs_pkg::frs_restart_t kind_of(input logic [2:0] m);
        case (m)
            `FRS_MODE_ZERO:       kind_of = frs_pkg::FRS_RS_ZERO;
            `FRS_MODE_MATCH:      kind_of = frs_pkg::FRS_RS_MATCH; // RL11
            `FRS_MODE_MATCH_TRIP: kind_of = frs_pkg::FRS_RS_MATCH; // RL11
            `FRS_MODE_ACTIVE:     kind_of = frs_pkg::FRS_RS_ACTIVE;
            default:              kind_of = frs_pkg::FRS_RS_NONE;
        endcase
    endfunction : kind_of

    logic [2:0] pf_mode;
    logic [2:0] ov_mode;
    logic [1:0] retry_lim;
    logic       stop_trip;

    always_comb begin
        pf_mode   = legal_mode(cfg.power_fail_restart_mode);
        ov_mode   = legal_mode(cfg.ovoc_restart_mode);
        retry_lim = (cfg.ovoc_retry_count < `FRS_RETRY_MIN) ? `FRS_RETRY_MIN
                                                            : cfg.ovoc_retry_count;
        // Reserved stop-state code reports the trip.
        case (cfg.stop_state_trip_select) // RL7
            `FRS_STOP_NO_TRIP:  stop_trip = 1'b0;
            `FRS_STOP_TRIP:     stop_trip = 1'b1;
            `FRS_STOP_NO_DECEL: stop_trip = 1'b0;
            default:            stop_trip = 1'b1; // RL17
        endcase
    end

    always_comb begin
        next_st                 = st;
        next_st.ctl.restart_req = 1'b0;
        if (tick && st.timer != 10'h000) begin
            next_st.timer = st.timer - 10'h001; // RL16
        end
        case (st.state)
            S_RUN: begin
                if (dropout) begin
                    next_st.ctl.output_enable = 1'b0; // RL2
                    if (!running && !(decel_stopping &&
                        cfg.stop_state_trip_select == `FRS_STOP_TRIP)) begin
                        // Stopped: only the trip report is decided here.
                        if (stop_trip && !(decel_stopping &&
                            cfg.stop_state_trip_select == `FRS_STOP_NO_DECEL)) begin
                            next_st.ctl.trip = 1'b1; // RL7
                        end
                    end else begin
                        next_st.mode  = pf_mode;
                        next_st.timer = clamp_wait(cfg.dropout_allowed_time,
                                                   `FRS_DROP_MAX); // RL15
                        next_st.state = S_PF_OUT;
                    end
                end else if (ovoc_fault) begin
                    next_st.ctl.output_enable = 1'b0;
                    next_st.mode              = ov_mode;
                    if (ov_mode == `FRS_MODE_TRIP || st.retries >= retry_lim) begin
                        next_st.ctl.trip  = 1'b1; // RL10
                        next_st.ctl.alarm_output = 1'b1;
                        next_st.state     = S_TRIPPED;
                    end else begin
                        next_st.retries = st.retries + 2'h1; // RL10
                        next_st.timer   = clamp_wait(cfg.ovoc_retry_wait,
                                                     `FRS_WAIT_MAX); // RL12
                        next_st.state   = S_OV_WAIT;
                    end
                end
            end
            S_PF_OUT: begin
                if (!dropout) begin
                    if (st.mode == `FRS_MODE_TRIP) begin
                        next_st.ctl.undervoltage_error = 1'b1; // RL1
                        next_st.ctl.alarm_output       = 1'b1; // RL1
                        next_st.state                  = S_TRIPPED;
                    end else begin
                        next_st.timer = clamp_wait(cfg.power_fail_retry_wait,
                                                   `FRS_WAIT_MAX); // RL14
                        next_st.state = S_PF_WAIT;
                    end
                end else if (st.timer == 10'h000) begin
                    // Too long a dropout trips in every mode.
                    next_st.ctl.undervoltage_error = 1'b1; // RL15
                    next_st.ctl.alarm_output       = 1'b1;
                    next_st.state                  = S_TRIPPED;
                end
            end
            S_PF_WAIT, S_OV_WAIT: begin
                if (st.state == S_PF_WAIT && dropout) begin
                    next_st.timer = clamp_wait(cfg.dropout_allowed_time, `FRS_DROP_MAX);
                    next_st.state = S_PF_OUT;
                end else if (st.timer == 10'h000) begin
                    if (st.state == S_OV_WAIT && ovoc_fault) begin
                        next_st.state = S_RUN; // RL13
                    end else begin
                        next_st.ctl.output_enable = 1'b1;
                        next_st.ctl.restart_req   = 1'b1; // RL3 RL4 RL6 RL9
                        next_st.ctl.restart_kind  = kind_of(st.mode);
                        if (st.mode == `FRS_MODE_MATCH_TRIP) begin
                            next_st.ctl.decel_stop_req = 1'b1; // RL5
                            next_st.state              = S_DECEL;
                        end else begin
                            next_st.state = S_RUN;
                        end
                    end
                end
            end
            S_DECEL: begin
                if (decel_done) begin
                    next_st.ctl.decel_stop_req = 1'b0;
                    next_st.ctl.alarm_output   = 1'b1; // RL5 RL9
                    next_st.ctl.trip           = 1'b1;
                    next_st.state              = S_TRIPPED;
                end
            end
            S_TRIPPED: begin
                next_st.ctl.output_enable = 1'b0;
            end
            default: begin
                next_st.state = S_TRIPPED;
            end
        endcase
        // A dropout cuts the output in every state, a ramp-down included.
        if (dropout) begin
            next_st.ctl.output_enable = 1'b0; // RL2
        end
        // The stop-state trip holds until control power is lost.
        if (!control_power) begin
            next_st.ctl.trip = 1'b0; // RL8
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st                   <= '0;
            st.state             <= S_RUN;
            st.ctl.output_enable <= 1'b1;
            st.retries           <= 2'h0; // RL16
        end else begin
            st <= next_st;
        end
    end

    assign ctl = st.ctl;

    sequence drop_seen_s;
        dropout;
    endsequence

    drop_cut_a: assert property (@(posedge clk) disable iff (rst)
        drop_seen_s |=> !ctl.output_enable) else $error("output not cut"); // RL2
    pf_trip_a: assert property (@(posedge clk) disable iff (rst)
        st.state == S_PF_OUT && !dropout && st.mode == `FRS_MODE_TRIP
        |=> ctl.undervoltage_error && ctl.alarm_output) else $error("no E on return"); // RL1
    pf_no_alarm_a: assert property (@(posedge clk) disable iff (rst)
        ctl.restart_req |-> !ctl.alarm_output) else $error("alarm on restart"); // RL3
    ov_retry_lim_a: assert property (@(posedge clk) disable iff (rst)
        st.state == S_RUN && !dropout && ovoc_fault && st.retries >= retry_lim
        |=> ctl.trip && ctl.alarm_output) else $error("retries not limited"); // RL10
    ov_wait_hold_a: assert property (@(posedge clk) disable iff (rst)
        st.state == S_OV_WAIT && st.timer != 10'h000 |=> !ctl.restart_req)
        else $error("early restart"); // RL12
    ov_refault_a: assert property (@(posedge clk) disable iff (rst)
        st.state == S_OV_WAIT && st.timer == 10'h000 && ovoc_fault
        |=> !ctl.restart_req && st.state == S_RUN) else $error("restart on fault"); // RL13
    match_kind_a: assert property (@(posedge clk) disable iff (rst)
        ctl.restart_req && (st.mode == `FRS_MODE_MATCH || st.mode == `FRS_MODE_MATCH_TRIP)
        |-> ctl.restart_kind == frs_pkg::FRS_RS_MATCH) else $error("wrong kind"); // RL11
    decel_alarm_a: assert property (@(posedge clk) disable iff (rst)
        st.state == S_DECEL && decel_done |=> ctl.alarm_output && ctl.trip)
        else $error("no alarm after decel"); // RL5
    trip_hold_a: assert property (@(posedge clk) disable iff (rst)
        ctl.trip && control_power |=> ctl.trip) else $error("trip dropped"); // RL8
    reserved_a: assert property (@(posedge clk) disable iff (rst)
        ctl.restart_req |-> ctl.restart_kind != frs_pkg::FRS_RS_NONE)
        else $error("restart on reserved"); // RL17
endmodule : frs_sequencer

// ==== frs_drive_model.sv ====
// Behavioural model of the drive around the sequencer: it answers a
// deceleration request by reporting standstill after a set delay.
// Assumes it shares clk and rst with the sequencer and sees its ctl output.
`timescale 1ns/100ps

module frs_drive_model #(
    parameter int DECEL_CYCLES = 16
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  frs_pkg::frs_ctl_t ctl,
    output logic              decel_done
);
    int unsigned decel_count;

    // =====================================================================
    // Deceleration response
    // A long count stands for a slow ramp; the sequencer must wait for it.
    always_ff @(posedge clk) begin
        if (rst || !ctl.decel_stop_req) begin
            decel_count <= 0;
            decel_done  <= 1'b0;
        end else if (decel_count == DECEL_CYCLES) begin
            decel_done <= 1'b1;
        end else begin
            decel_count <= decel_count + 1;
        end
    end
endmodule : frs_drive_model

// ==== testbench.sv ====
// Self-checking bench for the fault restart sequencer.
// Assumes the package and design files are compiled first; the tick period is
// shortened to 20 clocks so that whole waits and restarts fit in the run.
`timescale 1ns/100ps

module testbench;
    logic              clk;
    logic              rst;
    logic              dropout;
    logic              ovoc_fault;
    logic              running;
    logic              decel_stopping;
    logic              decel_done;
    logic              control_power;
    frs_pkg::frs_cfg_t cfg;
    frs_pkg::frs_ctl_t ctl;
    int                bad_count;
    int                samples_checked;
    logic [1:0]        sel_tab [3];
    frs_pkg::frs_restart_t kind_tab [5];

    frs_sequencer #(.TICK_CYCLES(20)) frs_sequencer_inst (
        .clk            (clk),
        .rst            (rst),
        .cfg            (cfg),
        .dropout        (dropout),
        .ovoc_fault     (ovoc_fault),
        .running        (running),
        .decel_stopping (decel_stopping),
        .decel_done     (decel_done),
        .control_power  (control_power),
        .ctl            (ctl)
    );

    frs_drive_model frs_drive_model_inst (
        .clk        (clk),
        .rst        (rst),
        .ctl        (ctl),
        .decel_done (decel_done)
    );

    // =====================================================================
    // Clock, tasks and verdict
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic give_verdict;
        $display("Checks made %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : cmp_bit

    task automatic cmp_kind(input string what, input frs_pkg::frs_restart_t exp,
                            input frs_pkg::frs_restart_t got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask : cmp_kind

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step

    task automatic do_reset(input int n);
        rst            = 1'b1;
        dropout        = 1'b0;
        ovoc_fault     = 1'b0;
        running        = 1'b1;
        decel_stopping = 1'b0;
        control_power  = 1'b1;
        step(n);
        rst = 1'b0;
    endtask : do_reset

    // A short dropout while running; power returns well inside the allowed time.
    task automatic dropout_cycle(input logic [2:0] mode);
        cfg.power_fail_restart_mode = mode;
        do_reset(2);
        dropout = 1'b1;
        step(2);
        cmp_bit("output_enable on dropout", 1'b0, ctl.output_enable);
        dropout = 1'b0;
        step(4);
    endtask : dropout_cycle

    // The shortest wait is three ticks (60 clocks), longer than the 10- and 20-cycle windows.
    task automatic watch_no_restart(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            cmp_bit("restart_req", 1'b0, ctl.restart_req);
        end
    endtask : watch_no_restart

    // Waits for the restart pulse and checks what it carries; mode 3 then ramps down.
    task automatic expect_restart(input int m);
        int n;
        n = 0;
        while (ctl.restart_req !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        cmp_bit("restart_req", 1'b1, ctl.restart_req);
        cmp_kind("restart_kind", kind_tab[m], ctl.restart_kind);
        cmp_bit("restart output_enable", 1'b1, ctl.output_enable);
        cmp_bit("restart alarm_output", 1'b0, ctl.alarm_output);
        if (m == 3) begin
            cmp_bit("decel_stop_req", 1'b1, ctl.decel_stop_req);
            step(25);
            cmp_bit("decel alarm_output", 1'b1, ctl.alarm_output);
        end
    endtask : expect_restart

    initial begin
        #(20 * 5000);
        bad_count++;
        give_verdict();
    end

    // =====================================================================
    // Tests
    initial begin
        bad_count       = 0;
        samples_checked = 0;
        sel_tab         = '{2'h0, 2'h2, 2'h1};
        kind_tab        = '{frs_pkg::FRS_RS_NONE, frs_pkg::FRS_RS_ZERO, frs_pkg::FRS_RS_MATCH,
                            frs_pkg::FRS_RS_MATCH, frs_pkg::FRS_RS_ACTIVE};
        cfg = '{power_fail_restart_mode: 3'h0, dropout_allowed_time: 10'h003,
                power_fail_retry_wait: 10'h003, stop_state_trip_select: 2'h0,
                ovoc_restart_mode: 3'h0, ovoc_retry_count: 2'h1,
                ovoc_retry_wait: 10'h003};
        do_reset(8);
        cmp_bit("reset output_enable", 1'b1, ctl.output_enable);
        cmp_bit("reset trip", 1'b0, ctl.trip);
        dropout_cycle(3'h0);
        cmp_bit("undervoltage_error", 1'b1, ctl.undervoltage_error);
        cmp_bit("alarm_output", 1'b1, ctl.alarm_output);
        for (int m = 1; m <= 7; m++) begin
            dropout_cycle(m[2:0]);
            if (m <= 4) begin
                watch_no_restart(20);
                cmp_bit("output_enable held off", 1'b0, ctl.output_enable);
                cmp_bit("alarm_output", 1'b0, ctl.alarm_output);
                cmp_bit("undervoltage_error", 1'b0, ctl.undervoltage_error);
                expect_restart(m);
            end else begin
                cmp_bit("reserved undervoltage_error", 1'b1, ctl.undervoltage_error);
            end
        end
        // A dropout that outlasts the allowed time trips even in a restart mode.
        cfg.power_fail_restart_mode = 3'h1;
        do_reset(2);
        dropout = 1'b1;
        watch_no_restart(90);
        cmp_bit("long dropout undervoltage_error", 1'b1, ctl.undervoltage_error);
        cfg.stop_state_trip_select = 2'h2;
        do_reset(2);
        running        = 1'b0;
        decel_stopping = 1'b1;
        dropout        = 1'b1;
        step(3);
        cmp_bit("decel stop trip", 1'b0, ctl.trip);
        cmp_bit("decel stop output_enable", 1'b0, ctl.output_enable);
        for (int s = 0; s < 3; s++) begin
            cfg.stop_state_trip_select = sel_tab[s];
            do_reset(2);
            running = 1'b0;
            dropout = 1'b1;
            step(3);
            dropout = 1'b0;
            step(3);
            cmp_bit("stop trip", sel_tab[s] == 2'h1, ctl.trip);
        end
        step(50);
        cmp_bit("trip held", 1'b1, ctl.trip);
        control_power = 1'b0;
        step(2);
        cmp_bit("trip cleared", 1'b0, ctl.trip);
        for (int m = 0; m <= 7; m++) begin
            cfg.ovoc_restart_mode = m[2:0];
            do_reset(2);
            ovoc_fault = 1'b1;
            step(2);
            ovoc_fault = 1'b0;
            cmp_bit("fault output_enable", 1'b0, ctl.output_enable);
            step(3);
            cmp_bit("fault trip", m == 0 || m > 4, ctl.trip);
            if (m >= 1 && m <= 4) begin
                watch_no_restart(10);
                expect_restart(m);
            end
        end
        // A fault that outlasts the wait is seen again after the only retry and trips.
        cfg.ovoc_restart_mode = 3'h1;
        do_reset(2);
        ovoc_fault = 1'b1;
        watch_no_restart(90);
        cmp_bit("refault trip", 1'b1, ctl.trip);
        // Two retries allowed: two faults restart, the third trips.
        cfg.ovoc_retry_count = 2'h2;
        do_reset(2);
        repeat (2) begin
            ovoc_fault = 1'b1;
            step(1);
            ovoc_fault = 1'b0;
            expect_restart(1);
        end
        ovoc_fault = 1'b1;
        step(2);
        cmp_bit("retries spent trip", 1'b1, ctl.trip);
        cmp_bit("retries spent alarm_output", 1'b1, ctl.alarm_output);
        give_verdict();
    end
endmodule : testbench
